// file: common/pbssp_pkg.sv
// Shared constants, types and functions for the pipelined burst SRAM port
package pbssp_pkg;

	// ============================================================
	// Widths and sizes
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int BYTE_N = 4;
	localparam int BYTE_W = 8;
	localparam int LOW_W = 2;
	localparam int WORDS = 262144;

	// ============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	// Sleep entry, exit and recovery, in clock periods
	localparam int SLEEP_TRANS_TCYC = 2;
	localparam int SLEEP_CYC = SLEEP_TRANS_TCYC;
	localparam logic [1:0] SLEEP_LAST = 2'(SLEEP_CYC - 1);
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;

	// ============================================================
	// Constant values
	localparam logic [LOW_W-1:0] STEP_ZERO = 2'h0;
	localparam logic [LOW_W-1:0] STEP_ONE = 2'h1;
	localparam logic [BYTE_N-1:0] ALL_BYTES = 4'hf;
	localparam logic [BYTE_N-1:0] NO_BYTES = 4'h0;
	localparam logic [DATA_W-1:0] DOUT_RST = 32'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0;

	// ============================================================
	// Types
	typedef enum logic [1:0] {SLP_AWAKE, SLP_ENTER, SLP_ASLEEP, SLP_WAKE}
		pbssp_sleep_t;

	typedef struct packed {
		logic proc_addr_strobe_n;
		logic ctrl_addr_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_enable_n;
		logic [BYTE_N-1:0] byte_select_n;
		logic chip_en_one_n;
		logic chip_en_two;
		logic chip_en_three_n;
		logic output_enable_n;
	} pbssp_ctl_t;

	// ============================================================
	// Functions
	function automatic logic [LOW_W-1:0] burst_addr(
		input logic [LOW_W-1:0] start,
		input logic [LOW_W-1:0] step,
		input logic interleaved
	);
		logic [LOW_W-1:0] res;
		if (interleaved)
		begin
			res = start ^ step;
		end
		else
		begin
			res = LOW_W'(start + step);
		end
		return res;
	endfunction

	function automatic logic [BYTE_N-1:0] byte_mask(input pbssp_ctl_t c);
		logic [BYTE_N-1:0] m;
		if (!c.global_write_n)
		begin
			m = ALL_BYTES;
		end
		else if (!c.byte_write_enable_n)
		begin
			m = ~c.byte_select_n;
		end
		else
		begin
			m = NO_BYTES;
		end
		return m;
	endfunction

	function automatic logic write_ind(input pbssp_ctl_t c);
		return |byte_mask(c);
	endfunction

endpackage

// file: logic/pbssp_burst_ctr.sv
// Two-bit wraparound burst counter with interleaved or linear order
module pbssp_burst_ctr (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Control
	input wire logic load_i,
	input wire logic [pbssp_pkg::LOW_W-1:0] start_i,
	input wire logic advance_i,
	input wire logic interleaved_i,
	// Burst address
	output logic [pbssp_pkg::LOW_W-1:0] cur_o,
	output logic [pbssp_pkg::LOW_W-1:0] nxt_o
);
	import pbssp_pkg::*;

	logic [LOW_W-1:0] start_q;
	logic [LOW_W-1:0] start_d;
	logic [LOW_W-1:0] step_q;
	logic [LOW_W-1:0] step_d;

	// ============================================================
	// Next state
	always_comb
	begin
		start_d = start_q;
		step_d = step_q;
		if (load_i)
		begin
			start_d = start_i;
			step_d = STEP_ZERO;
		end
		else if (advance_i)
		begin
			step_d = LOW_W'(step_q + STEP_ONE);
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			start_q <= STEP_ZERO;
			step_q <= STEP_ZERO;
		end
		else
		begin
			start_q <= start_d;
			step_q <= step_d;
		end
	end

	// Order taken from the strap
	assign cur_o = burst_addr(start_q, step_q, interleaved_i);
	assign nxt_o = burst_addr(start_q, LOW_W'(step_q + STEP_ONE),
		interleaved_i);

	// ============================================================
	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	ctr_load_a: assert property (load_i |=> cur_o == $past(start_i))
		else $error("burst counter did not load start address");

	interleave_step_a: assert property (
		(!load_i && advance_i && interleaved_i) ##1 interleaved_i
		|-> cur_o == (start_q ^ step_q) && step_q == $past(step_q) + 2'h1)
		else $error("interleaved step wrong");

	linear_step_a: assert property (
		(!load_i && advance_i && !interleaved_i) ##1 !interleaved_i
		|-> cur_o == 2'($past(cur_o) + 2'h1))
		else $error("linear step wrong");

	suspend_hold_a: assert property (
		(!load_i && !advance_i) ##1 $stable(interleaved_i)
		|-> $stable(cur_o))
		else $error("burst address moved while suspended");

endmodule

// file: logic/pbssp_port.sv
// Pipelined burst synchronous SRAM port with common data I/O
//
// Behaviour
// - Inputs captured and read data registered
// - Strap picks interleaved or linear order
// - Interleaved burst XORs start with step
// - Linear burst adds step modulo four
// - Advance low steps the burst counter
// - Strobe with chips active starts read; controller strobe with write starts write
// - Data one edge after capture, back-to-back
// - First cycle after deselect stays tri-stated
// - Deselect keeps driving one more cycle
// - Processor strobe ignores writes and advance
// - Processor write stored at second edge
// - Global write stores all four bytes
// - Byte writes store only selected bytes
// - Any write cycle tri-states outputs
// - Controller strobe write takes one cycle
// - Sleep tri-states, retains, two-cycle transitions
// - Access pending at sleep is dropped
// - Strobe with bad chip enables gives deselect; processor strobe needs chip enable one low
// - Processor strobe with chips active always begins read burst
// - Processor strobe wins over controller strobe
// - Write indication from global or byte write
// - No strobe, no advance holds address
module pbssp_port (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Bus controls, address, strap and sleep
	input wire pbssp_pkg::pbssp_ctl_t ctl_i,
	input wire logic [pbssp_pkg::ADDR_W-1:0] addr_i,
	input wire logic mode_strap_i,
	input wire logic sleep_request_i,
	// Data pins
	input wire logic [pbssp_pkg::DATA_W-1:0] dq_i,
	output logic [pbssp_pkg::DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	// Status
	output logic asleep_o
);
	import pbssp_pkg::*;

	// ============================================================
	// Storage and state
	logic [DATA_W-1:0] mem [0:WORDS-1];

	logic act_q;
	logic act_d;
	logic rd_q;
	logic rd_d;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [ADDR_W-1:0] rd_addr_d;
	logic [ADDR_W-LOW_W-1:0] upper_q;
	logic [ADDR_W-LOW_W-1:0] upper_d;
	logic [DATA_W-1:0] dout_q;
	logic [DATA_W-1:0] dout_d;
	logic oe_q;
	logic oe_d;
	pbssp_sleep_t slp_q;
	pbssp_sleep_t slp_d;
	logic [1:0] slp_cnt_q;
	logic [1:0] slp_cnt_d;
	logic asleep_q;
	logic asleep_d;

	// ============================================================
	// Decode
	logic proc_ld;
	logic any_ld;
	logic chips_ok;
	logic quiet;
	logic new_acc;
	logic desel;
	logic cont;
	logic is_wr;
	logic is_rd;
	logic step;
	logic [BYTE_N-1:0] wr_mask;
	logic [LOW_W-1:0] low_cur;
	logic [LOW_W-1:0] low_nxt;
	logic [LOW_W-1:0] low_eff;
	logic [ADDR_W-1:0] eff_addr;

	always_comb
	begin
		// Processor strobe counts only with chip enable one low
		proc_ld = !ctl_i.proc_addr_strobe_n && !ctl_i.chip_en_one_n;
		any_ld = proc_ld || !ctl_i.ctrl_addr_strobe_n;
		chips_ok = !ctl_i.chip_en_one_n && ctl_i.chip_en_two
			&& !ctl_i.chip_en_three_n;
		quiet = (slp_q != SLP_AWAKE) || sleep_request_i;
		new_acc = !quiet && any_ld && chips_ok;
		desel = any_ld && !chips_ok;
		cont = !quiet && !any_ld && act_q;
		wr_mask = byte_mask(ctl_i);
		// Processor load is always a read
		is_wr = (new_acc && !proc_ld && write_ind(ctl_i))
			|| (cont && write_ind(ctl_i));
		is_rd = (new_acc && (proc_ld || !write_ind(ctl_i)))
			|| (cont && !write_ind(ctl_i));
		step = cont && !ctl_i.burst_advance_n;
		if (new_acc)
		begin
			low_eff = addr_i[LOW_W-1:0];
		end
		else if (step)
		begin
			low_eff = low_nxt;
		end
		else
		begin
			low_eff = low_cur;
		end
		eff_addr = new_acc ? addr_i : {upper_q, low_eff};
	end

	pbssp_burst_ctr u_burst_ctr (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.load_i(new_acc),
		.start_i(addr_i[LOW_W-1:0]),
		.advance_i(step),
		.interleaved_i(mode_strap_i),
		.cur_o(low_cur),
		.nxt_o(low_nxt)
	);

	// ============================================================
	// Array write, data captured at the write edge
	always_ff @(posedge core_clk_i)
	begin
		if (is_wr)
		begin
			for (int b = 0; b < BYTE_N; b++)
			begin
				if (wr_mask[b])
				begin
					mem[eff_addr][b*BYTE_W +: BYTE_W] <=
						dq_i[b*BYTE_W +: BYTE_W];
				end
			end
		end
	end

	// ============================================================
	// Access pipeline and output drive
	always_comb
	begin
		act_d = act_q;
		if (quiet)
		begin
			act_d = 1'b0;
		end
		else if (any_ld)
		begin
			act_d = chips_ok;
		end
		rd_d = is_rd;
		rd_addr_d = is_rd ? eff_addr : rd_addr_q;
		upper_d = new_acc ? addr_i[ADDR_W-1:LOW_W] : upper_q;
		dout_d = rd_q ? mem[rd_addr_q] : dout_q;
		// Drive only for a read taken the edge before; a fresh access
		// out of deselect has no such read and stays off
		oe_d = rd_q && !ctl_i.output_enable_n && !is_wr
			&& !quiet;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			act_q <= 1'b0;
			rd_q <= 1'b0;
			rd_addr_q <= ADDR_RST;
			upper_q <= ADDR_RST[ADDR_W-1:LOW_W];
			dout_q <= DOUT_RST;
			oe_q <= 1'b0;
		end
		else
		begin
			act_q <= act_d;
			rd_q <= rd_d;
			rd_addr_q <= rd_addr_d;
			upper_q <= upper_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
		end
	end

	// ============================================================
	// Sleep sequencing
	always_comb
	begin
		slp_d = slp_q;
		slp_cnt_d = CNT_ZERO;
		unique case (slp_q)
			SLP_AWAKE:
			begin
				if (sleep_request_i)
				begin
					slp_d = SLP_ENTER;
					slp_cnt_d = CNT_ONE;
				end
			end
			SLP_ENTER:
			begin
				if (!sleep_request_i)
				begin
					slp_d = SLP_AWAKE;
				end
				else if (slp_cnt_q == SLEEP_LAST)
				begin
					slp_d = SLP_ASLEEP;
				end
				else
				begin
					slp_cnt_d = 2'(slp_cnt_q + CNT_ONE);
				end
			end
			SLP_ASLEEP:
			begin
				if (!sleep_request_i)
				begin
					slp_d = SLP_WAKE;
					slp_cnt_d = CNT_ONE;
				end
			end
			SLP_WAKE:
			begin
				if (sleep_request_i)
				begin
					slp_d = SLP_ASLEEP;
				end
				else if (slp_cnt_q == SLEEP_LAST)
				begin
					slp_d = SLP_AWAKE;
				end
				else
				begin
					slp_cnt_d = 2'(slp_cnt_q + CNT_ONE);
				end
			end
		endcase
		asleep_d = (slp_d == SLP_ASLEEP) || (slp_d == SLP_WAKE);
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			slp_q <= SLP_AWAKE;
			slp_cnt_q <= CNT_ZERO;
			asleep_q <= 1'b0;
		end
		else
		begin
			slp_q <= slp_d;
			slp_cnt_q <= slp_cnt_d;
			asleep_q <= asleep_d;
		end
	end

	// ============================================================
	// Outputs
	assign dq_o = dout_q;
	assign dq_oe_o = oe_q;
	assign asleep_o = asleep_q;

	// ============================================================
	// Checks
	sequence s_read_taken;
		is_rd;
	endsequence

	sequence s_drive_ok;
		!ctl_i.output_enable_n && !is_wr && !quiet;
	endsequence

	sequence s_proc_load;
		new_acc && proc_ld;
	endsequence

	sequence s_desel_reading;
		rd_q && desel && !ctl_i.output_enable_n && !quiet && !is_wr;
	endsequence

	property p_read_drives;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		s_read_taken ##1 s_drive_ok |=> dq_oe_o;
	endproperty

	read_drive_a: assert property (p_read_drives)
		else $error("read data not driven after capture");

	first_mask_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(!act_q && !rd_q && new_acc) |=> !dq_oe_o)
		else $error("outputs driven in first cycle after deselect");

	dcd_hold_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		s_desel_reading |=> dq_oe_o ##1 !dq_oe_o)
		else $error("double-cycle deselect timing wrong");

	write_tri_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		is_wr |=> !dq_oe_o)
		else $error("outputs driven during write cycle");

	proc_read_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		s_proc_load |-> is_rd && !is_wr && !step)
		else $error("processor strobe load not a plain read");

	proc_write_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		s_proc_load ##1 (!any_ld && write_ind(ctl_i) && !quiet)
		|-> is_wr && eff_addr[ADDR_W-1:LOW_W] == upper_q)
		else $error("processor write not taken at second edge");

	global_mask_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!ctl_i.global_write_n |-> wr_mask == ALL_BYTES)
		else $error("global write did not select all bytes");

	sleep_tri_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		sleep_request_i |=> !dq_oe_o && !act_q)
		else $error("sleep did not tri-state or drop access");

	sleep_entry_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(slp_q == SLP_AWAKE && sleep_request_i) ##1 sleep_request_i
		|=> asleep_o)
		else $error("sleep entry not two cycles");

	sleep_exit_a: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(slp_q == SLP_ASLEEP && !sleep_request_i) ##1 !sleep_request_i
		|-> quiet ##1 !asleep_o)
		else $error("sleep exit not two cycles");

endmodule

// file: tb/pbssp_ctrl_model.sv
// Controller-side bus driver for the burst SRAM port
module pbssp_ctrl_model (
	// Clock
	input wire logic core_clk_i,
	// Bus towards the port
	output pbssp_pkg::pbssp_ctl_t ctl_o,
	output logic [pbssp_pkg::ADDR_W-1:0] addr_o,
	output logic [pbssp_pkg::DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic sleep_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pbssp_pkg::*;

	// ========
	// Idle bus: no strobes, chips off, outputs disabled
	localparam pbssp_ctl_t IDLE = 13'h1ffb;

	initial
	begin
		ctl_o = IDLE;
		addr_o = 18'h0;
		dq_o = 32'h0;
		dq_oe_o = 1'h0;
		sleep_o = 1'h0;
	end

	// ========
	// One bus cycle; released data lines change every cycle
	task automatic cyc(input pbssp_ctl_t c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic wr);
		@(posedge core_clk_i);
		ctl_o <= c;
		addr_o <= a;
		dq_oe_o <= wr;
		dq_o <= wr ? d : ~dq_o;
	endtask

	// ========
	// Sleep for n edges with the bus deselected around it
	task automatic doze(input int n);
		cyc(IDLE, addr_o, dq_o, 1'h0);
		sleep_o <= 1'h1;
		repeat (n) @(posedge core_clk_i);
		sleep_o <= 1'h0;
		repeat (3) cyc(IDLE, addr_o, dq_o, 1'h0);
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the burst SRAM port
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pbssp_pkg::*;

	// ========
	// Signals
	localparam pbssp_ctl_t IDLE = 13'h1ffb;
	logic core_clk = 1'h0;
	logic reset_n = 1'h0;
	logic mode_strap = 1'h1;
	pbssp_ctl_t ctl;
	logic [ADDR_W-1:0] addr, a;
	logic [DATA_W-1:0] m_dq, d_dq, dq_w, ed;
	logic m_oe, d_oe, sleep_req, asleep;
	logic s1 = 1'h0;
	logic s2 = 1'h0;
	logic ea = 1'h0;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] exp_q [$];
	int bad_count = 0;
	int check_count = 0;

	always #4 core_clk = ~core_clk;
	assign dq_w = d_oe ? d_dq : (m_oe ? m_dq : ~m_dq);

	pbssp_ctrl_model i_pbssp_ctrl_model (
		.core_clk_i(core_clk),
		.ctl_o(ctl),
		.addr_o(addr),
		.dq_o(m_dq),
		.dq_oe_o(m_oe),
		.sleep_o(sleep_req)
	);

	pbssp_port i_pbssp_port (
		.core_clk_i(core_clk),
		.reset_n_i(reset_n),
		.ctl_i(ctl),
		.addr_i(addr),
		.mode_strap_i(mode_strap),
		.sleep_request_i(sleep_req),
		.dq_i(dq_w),
		.dq_o(d_dq),
		.dq_oe_o(d_oe),
		.asleep_o(asleep)
	);

	// ========
	// Checks and verdict
	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ========
	// Helpers
	function automatic pbssp_ctl_t sel(input logic p, input logic c,
		input logic oe);
		pbssp_ctl_t r;
		r = IDLE;
		r.proc_addr_strobe_n = p;
		r.ctrl_addr_strobe_n = c;
		r.output_enable_n = oe;
		r.chip_en_one_n = 1'h0;
		r.chip_en_two = 1'h1;
		r.chip_en_three_n = 1'h0;
		return r;
	endfunction

	function automatic logic [ADDR_W-1:0] ba(input logic [ADDR_W-1:0] s,
		input int k);
		logic [1:0] lo;
		lo = mode_strap ? s[1:0] ^ 2'(k) : 2'(s[1:0] + 2'(k));
		return {s[17:2], lo};
	endfunction

	function automatic logic [DATA_W-1:0] wm(inout pbssp_ctl_t c,
		input bit full);
		logic [DATA_W-1:0] m;
		c.global_write_n = full ? 1'h0 : 1'($urandom_range(1));
		c.byte_write_enable_n = 1'($urandom_range(1));
		c.byte_select_n = 4'($urandom_range(15));
		for (int b = 0; b < BYTE_N; b++)
			m[8*b+:8] = {8{!c.global_write_n ||
				(!c.byte_write_enable_n && !c.byte_select_n[b])}};
		return m;
	endfunction

	// ========
	// Bus sequences
	task automatic desel(input logic oe);
		pbssp_ctl_t c;
		c = sel(1'($urandom_range(1)), 1'h0, oe);
		case (2'($urandom_range(2)))
			2'h0: c.chip_en_one_n = 1'h1;
			2'h1: c.chip_en_two = 1'h0;
			default: c.chip_en_three_n = 1'h1;
		endcase
		i_pbssp_ctrl_model.cyc(c, a, 32'h0, 1'h0);
		c = IDLE;
		c.output_enable_n = 1'h0;
		i_pbssp_ctrl_model.cyc(c, a, 32'h0, 1'h0);
	endtask

	task automatic wburst(input logic [ADDR_W-1:0] s, input int n,
		input bit full);
		pbssp_ctl_t c;
		logic [DATA_W-1:0] d, m;
		int k;
		k = 0;
		for (int j = 0; j < n; j++)
		begin
			c = sel(1'h1, j > 0, 1'h1);
			c.burst_advance_n = full ? 1'h0 : 1'($urandom_range(1));
			m = wm(c, full);
			d = $urandom;
			k += (j > 0 && !c.burst_advance_n);
			mem[ba(s, k)] = (mem[ba(s, k)] & ~m) | (d & m);
			i_pbssp_ctrl_model.cyc(c, s, d, 1'h1);
		end
		desel(1'h1);
	endtask

	task automatic pwrite(input logic [ADDR_W-1:0] s, input logic oe);
		pbssp_ctl_t c;
		logic [DATA_W-1:0] d, m;
		c = sel(1'h0, 1'h1, 1'h1);
		m = wm(c, 1'h0);
		c.burst_advance_n = 1'h0;
		i_pbssp_ctrl_model.cyc(c, s, 32'h0, 1'h0);
		c = sel(1'h1, 1'h1, oe);
		m = wm(c, 1'h0);
		if (m === 32'h0)
		begin
			c.global_write_n = 1'h0;
			m = 32'hffffffff;
		end
		d = $urandom;
		mem[s] = (mem[s] & ~m) | (d & m);
		i_pbssp_ctrl_model.cyc(c, s, d, 1'h1);
		desel(1'h1);
	endtask

	task automatic rburst(input logic [ADDR_W-1:0] s, input int n,
		input bit last);
		pbssp_ctl_t c;
		int k;
		k = 0;
		c = sel(1'($urandom_range(1)), 1'h0, 1'h0);
		void'(wm(c, 1'h0));
		// Controller strobe alone starts a read only with writes idle
		if (c.proc_addr_strobe_n)
		begin
			c.global_write_n = 1'h1;
			c.byte_write_enable_n = 1'h1;
		end
		c.burst_advance_n = 1'h0;
		for (int j = 0; j < n; j++)
		begin
			exp_q.push_back(mem[ba(s, k)]);
			i_pbssp_ctrl_model.cyc(c, s, 32'h0, 1'h0);
			c = sel(1'h1, 1'h1, 1'h0);
			c.burst_advance_n = 1'($urandom_range(1));
			k += !c.burst_advance_n;
		end
		if (last)
			desel(1'h0);
	endtask

	// ========
	// Output watcher
	always @(negedge core_clk)
	begin
		if (reset_n)
		begin
			if (s1 == s2)
				ea = s1;
			check_bit(asleep, ea);
			if (d_oe !== 1'h0)
			begin
				ed = (exp_q.size() > 0) ? exp_q.pop_front() : ~d_dq;
				check_data(d_dq, ed);
			end
		end
		s2 = s1;
		s1 = sleep_req;
	end

	// ========
	// Main sequence and watchdog
	initial
	begin
		void'($urandom(24295));
		repeat (2) @(posedge core_clk);
		reset_n <= 1'h1;
		for (int md = 0; md < 2; md++)
		begin
			mode_strap <= 1'(md);
			for (int t = 0; t < 8; t++)
			begin
				a = 18'($urandom);
				wburst(a, 4, 1'h1);
				wburst({a[17:2], 2'($urandom)}, 1 + $urandom_range(4), 1'h0);
				pwrite({a[17:2], 2'($urandom)}, 1'(t));
				rburst({a[17:2], 2'($urandom)}, 1, 1'h0);
				rburst({a[17:2], 2'($urandom)}, 2 + $urandom_range(3), 1'h1);
			end
		end
		i_pbssp_ctrl_model.doze(1);
		i_pbssp_ctrl_model.doze(4);
		rburst(a, 4, 1'h1);
		repeat (4) @(posedge core_clk);
		check_data(32'(exp_q.size()), 32'h0);
		report_and_stop();
	end

	initial
	begin
		#40000;
		bad_count++;
		report_and_stop();
	end
endmodule
